//--- design/gbt_top.sv
// Group base timer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "gbt_regs.svh"
module gbt_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [`GBT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`GBT_DATA_W-1:0] s_axi_wdata,
  input wire logic [`GBT_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`GBT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`GBT_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic ext_irq_pin_zero_n,
  input wire logic ext_irq_pin_one_n,
  input wire logic phase_a,
  input wire logic phase_b
);
  // ========================================================================
  // Registers
  logic [1:0] start_bits;
  logic [7:0] group_base_control_one;
  logic [`GBT_CNT_W-1:0] group_compare_zero;
  logic [`GBT_CNT_W-1:0] divisor;
  logic [`GBT_CNT_W-1:0] div_cnt;
  logic [`GBT_ADDR_W-1:0] waddr_q;
  logic [`GBT_DATA_W-1:0] wdata_q;
  logic [`GBT_STRB_W-1:0] wstrb_q;
  logic pha_d;
  wire logic [`GBT_DATA_W-1:0] v_start;
  wire logic [`GBT_DATA_W-1:0] v_ctrl1;
  wire logic [`GBT_DATA_W-1:0] v_cmp0;
  wire logic [`GBT_DATA_W-1:0] v_count;
  wire logic [`GBT_DATA_W-1:0] v_div;
  wire logic [`GBT_DATA_W-1:0] wmask;
  wire logic [`GBT_DATA_W-1:0] n_start;
  wire logic [`GBT_DATA_W-1:0] n_ctrl1;
  wire logic [`GBT_DATA_W-1:0] n_cmp0;
  wire logic [`GBT_DATA_W-1:0] n_div;
  wire logic [`GBT_DATA_W-1:0] rd_word;
  wire logic [`GBT_NPINS-1:0] pin_raw;
  wire logic [`GBT_NPINS-1:0] pin_f;
  wire logic do_write;
  wire logic wr_start;
  wire logic wr_ctrl1;
  wire logic wr_cmp0;
  wire logic wr_count;
  wire logic wr_div;
  wire logic wr_ok;
  wire logic rd_ok;
  wire logic tick;
  wire logic a_rise;

  gbt_ctl_if ctl ();

  // ========================================================================
  // Register views and byte lane merge
  assign v_start = {{(`GBT_DATA_W-2){1'b0}}, start_bits};
  assign v_ctrl1 = {{(`GBT_DATA_W-8){1'b0}}, group_base_control_one};
  assign v_cmp0 = {{(`GBT_DATA_W-`GBT_CNT_W){1'b0}}, group_compare_zero};
  assign v_div = {{(`GBT_DATA_W-`GBT_CNT_W){1'b0}}, divisor};
  assign v_count = {{(`GBT_DATA_W-`GBT_CNT_W-1){1'b0}}, ctl.dir_down,
                    ctl.count};

  genvar gb;
  for (gb = 0; gb < `GBT_STRB_W; gb++) begin : g_mask
    assign wmask[gb*8 +: 8] = {8{wstrb_q[gb]}};
  end

  assign n_start = (v_start & ~wmask) | (wdata_q & wmask);
  assign n_ctrl1 = (v_ctrl1 & ~wmask) | (wdata_q & wmask);
  assign n_cmp0 = (v_cmp0 & ~wmask) | (wdata_q & wmask);
  assign n_div = (v_div & ~wmask) | (wdata_q & wmask);

  // ========================================================================
  // Write channel: address and data are taken in either order
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_start = do_write && (waddr_q == `GBT_OFS_START);
  assign wr_ctrl1 = do_write && (waddr_q == `GBT_OFS_CTRL1);
  assign wr_cmp0 = do_write && (waddr_q == `GBT_OFS_CMP0);
  assign wr_count = do_write && (waddr_q == `GBT_OFS_COUNT);
  assign wr_div = do_write && (waddr_q == `GBT_OFS_DIV);
  assign wr_ok = wr_start || wr_ctrl1 || wr_cmp0 || wr_count || wr_div;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GBT_RESP_OKAY;
      waddr_q <= `GBT_OFS_START;
      wdata_q <= {`GBT_DATA_W{1'b0}};
      wstrb_q <= {`GBT_STRB_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `GBT_RESP_OKAY : `GBT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_bits <= 2'h0;
      group_base_control_one <= 8'h00;
      group_compare_zero <= `GBT_CNT_MIN;
      divisor <= `GBT_DIV_RST;
    end else begin
      if (wr_start) begin
        start_bits <= n_start[1:0];
      end
      if (wr_ctrl1) begin
        group_base_control_one <= n_ctrl1[7:0];
      end
      if (wr_cmp0) begin
        group_compare_zero <= n_cmp0[`GBT_CNT_W-1:0];
      end
      if (wr_div) begin
        divisor <= n_div[`GBT_CNT_W-1:0];
      end
    end
  end

  // ========================================================================
  // Read channel
  assign rd_ok = (s_axi_araddr == `GBT_OFS_START) ||
                 (s_axi_araddr == `GBT_OFS_CTRL1) ||
                 (s_axi_araddr == `GBT_OFS_CMP0) ||
                 (s_axi_araddr == `GBT_OFS_COUNT) ||
                 (s_axi_araddr == `GBT_OFS_DIV);
  assign rd_word = (s_axi_araddr == `GBT_OFS_START) ? v_start :
                   (s_axi_araddr == `GBT_OFS_CTRL1) ? v_ctrl1 :
                   (s_axi_araddr == `GBT_OFS_CMP0) ? v_cmp0 :
                   (s_axi_araddr == `GBT_OFS_COUNT) ? v_count :
                   (s_axi_araddr == `GBT_OFS_DIV) ? v_div :
                   {`GBT_DATA_W{1'b0}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {`GBT_DATA_W{1'b0}};
      s_axi_rresp <= `GBT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `GBT_RESP_OKAY : `GBT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  assign pin_raw = {phase_b, phase_a, ext_irq_pin_one_n, ext_irq_pin_zero_n};

  genvar gi;
  for (gi = 0; gi < `GBT_NPINS; gi++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic f;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1 <= 1'b1;
        s2 <= 1'b1;
        s3 <= 1'b1;
        f <= 1'b1;
      end else begin
        s1 <= pin_raw[gi];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          f <= s3;
        end
      end
    end
    assign pin_f[gi] = f;
  end

  // ========================================================================
  // Count source divider and two-phase decode
  assign tick = (div_cnt >= divisor);
  assign a_rise = pin_f[`GBT_PIN_PHA] && !pha_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= `GBT_CNT_MIN;
      pha_d <= 1'b1;
    end else begin
      div_cnt <= tick ? `GBT_CNT_MIN : div_cnt + `GBT_CNT_STEP;
      pha_d <= pin_f[`GBT_PIN_PHA];
    end
  end

  // ========================================================================
  // Core
  assign ctl.run = start_bits[`GBT_BIT_GSTART] ||
                   start_bits[`GBT_BIT_GRPSTART];
  assign ctl.tick = tick;
  assign ctl.mode = group_base_control_one[`GBT_MODE_MSB:`GBT_MODE_LSB];
  assign ctl.match_sel = group_base_control_one[`GBT_BIT_MATCH];
  assign ctl.rsrc = group_base_control_one[`GBT_RSRC_MSB:`GBT_RSRC_LSB];
  assign ctl.cmp = group_compare_zero;
  assign ctl.irq_n = pin_f[`GBT_PIN_IRQ1:`GBT_PIN_IRQ0];
  assign ctl.quad_up = a_rise && !pin_f[`GBT_PIN_PHB];
  assign ctl.quad_dn = a_rise && pin_f[`GBT_PIN_PHB];

  gbt_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(ctl)
  );

  // ========================================================================
  // Checks
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    wr_start && wstrb_q[0] &&
    (wdata_q[`GBT_BIT_GSTART] || wdata_q[`GBT_BIT_GRPSTART]) |=> ctl.run;
  endproperty
  a_start: assert property (p_start)
    else $error("Start bit write did not start timer");

  property p_mode_map;
    @(posedge aclk) disable iff (!aresetn)
    wr_ctrl1 && wstrb_q[0]
    |=> ctl.mode == $past(wdata_q[`GBT_MODE_MSB:`GBT_MODE_LSB]);
  endproperty
  a_mode_map: assert property (p_mode_map)
    else $error("Mode field not taken from bits 6 and 5");
endmodule : gbt_top
`default_nettype wire

//--- design/gbt_regs.svh
// Register map, field positions and fixed values of the group base timer
// Notes on behaviour
// - Either start bit set starts counting
// - Up/down mode reverses downward at FFFFh
// - Up/down match reset: down two counts after match
// - Up/down counting down turns upward at 0000h
// - Mode field b6:b5 selects counting mode
// - Low selected interrupt pin resets timer
// - Reset source 000b: timer runs freely
`ifndef GBT_REGS_SVH
`define GBT_REGS_SVH

// ==========================================================================
// Bus geometry
`define GBT_ADDR_W 8
`define GBT_DATA_W 32
`define GBT_STRB_W 4
`define GBT_CNT_W 16

// ==========================================================================
// Register offsets
`define GBT_OFS_START 8'h00
`define GBT_OFS_CTRL1 8'h04
`define GBT_OFS_CMP0 8'h08
`define GBT_OFS_COUNT 8'h0c
`define GBT_OFS_DIV 8'h10

// ==========================================================================
// Field positions
`define GBT_BIT_GSTART 0
`define GBT_BIT_GRPSTART 1
`define GBT_RSRC_LSB 0
`define GBT_RSRC_MSB 2
`define GBT_BIT_MATCH 3
`define GBT_MODE_LSB 5
`define GBT_MODE_MSB 6
`define GBT_BIT_DIR 16

// ==========================================================================
// Values
`define GBT_RSRC_NONE 3'h0
`define GBT_RSRC_PIN0 3'h1
`define GBT_RSRC_PIN1 3'h2
`define GBT_CNT_MAX 16'hffff
`define GBT_CNT_MIN 16'h0000
`define GBT_CNT_STEP 16'h0001
`define GBT_DIV_RST 16'h0000
`define GBT_RESP_OKAY 2'h0
`define GBT_RESP_SLVERR 2'h2

// ==========================================================================
// Synchronised pins
`define GBT_NPINS 4
`define GBT_PIN_IRQ0 0
`define GBT_PIN_IRQ1 1
`define GBT_PIN_PHA 2
`define GBT_PIN_PHB 3

`endif

//--- design/gbt_pkg.sv
// Types of the group base timer
`default_nettype none
package gbt_pkg;
  typedef enum logic [1:0] {
    gbt_mode_inc = 2'h0,
    gbt_mode_updn = 2'h1,
    gbt_mode_2ph = 2'h2,
    gbt_mode_rsvd = 2'h3
  } gbt_mode_t;

  typedef enum logic {
    gbt_dir_up = 1'h0,
    gbt_dir_down = 1'h1
  } gbt_dir_t;
endpackage : gbt_pkg
`default_nettype wire

//--- design/gbt_ctl_if.sv
// Control and status bundle between the register side and the counter core
`timescale 1ns/1ps
`default_nettype none
`include "gbt_regs.svh"
interface gbt_ctl_if;
  logic run;
  logic tick;
  logic [1:0] mode;
  logic match_sel;
  logic [2:0] rsrc;
  logic [`GBT_CNT_W-1:0] cmp;
  logic [1:0] irq_n;
  logic quad_up;
  logic quad_dn;
  logic [`GBT_CNT_W-1:0] count;
  logic dir_down;

  modport top (output run, tick, mode, match_sel, rsrc, cmp, irq_n,
               quad_up, quad_dn, input count, dir_down);
  modport core (input run, tick, mode, match_sel, rsrc, cmp, irq_n,
                quad_up, quad_dn, output count, dir_down);
endinterface : gbt_ctl_if
`default_nettype wire

//--- design/gbt_core.sv
// Counter core of the group base timer
`timescale 1ns/1ps
`default_nettype none
`include "gbt_regs.svh"
module gbt_core (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and status
  gbt_ctl_if.core ctl
);
  // ========================================================================
  // Decode
  gbt_pkg::gbt_mode_t mode;
  gbt_pkg::gbt_dir_t dir;
  gbt_pkg::gbt_dir_t next_dir;
  logic [`GBT_CNT_W-1:0] count;
  logic [`GBT_CNT_W-1:0] next_count;
  wire logic [`GBT_CNT_W-1:0] cmp_plus;
  wire logic ext_rst;
  wire logic hit;
  wire logic turn;

  assign mode = gbt_pkg::gbt_mode_t'(ctl.mode);
  assign cmp_plus = ctl.cmp + `GBT_CNT_STEP;
  // Source 000b and unused codes never reset the timer
  assign ext_rst = ((ctl.rsrc == `GBT_RSRC_PIN0) && !ctl.irq_n[0]) ||
                   ((ctl.rsrc == `GBT_RSRC_PIN1) && !ctl.irq_n[1]);
  assign hit = ctl.match_sel && (count == ctl.cmp);
  // Turning one count past the match makes the first down step the second
  assign turn = ctl.match_sel && (ctl.cmp != `GBT_CNT_MAX) &&
                (count == cmp_plus);

  // ========================================================================
  // Next state
  always_comb begin
    next_count = count;
    next_dir = dir;
    if (ext_rst) begin
      next_count = `GBT_CNT_MIN;
      next_dir = gbt_pkg::gbt_dir_up;
    end else if (ctl.run) begin
      case (mode)
        gbt_pkg::gbt_mode_inc: begin
          if (ctl.tick) begin
            next_dir = gbt_pkg::gbt_dir_up;
            next_count = hit ? `GBT_CNT_MIN : count + `GBT_CNT_STEP;
          end
        end
        gbt_pkg::gbt_mode_updn: begin
          if (ctl.tick) begin
            case (dir)
              gbt_pkg::gbt_dir_up: begin
                if ((count == `GBT_CNT_MAX) || turn) begin
                  next_dir = gbt_pkg::gbt_dir_down;
                  next_count = count - `GBT_CNT_STEP;
                end else begin
                  next_count = count + `GBT_CNT_STEP;
                end
              end
              gbt_pkg::gbt_dir_down: begin
                if (count == `GBT_CNT_MIN) begin
                  next_dir = gbt_pkg::gbt_dir_up;
                  next_count = count + `GBT_CNT_STEP;
                end else begin
                  next_count = count - `GBT_CNT_STEP;
                end
              end
              default: begin
                next_dir = gbt_pkg::gbt_dir_up;
              end
            endcase
          end
        end
        gbt_pkg::gbt_mode_2ph: begin
          // The phase pins are the count source in this mode
          if (ctl.quad_up) begin
            next_count = count + `GBT_CNT_STEP;
          end else if (ctl.quad_dn) begin
            next_count = count - `GBT_CNT_STEP;
          end
        end
        default: begin
          // Reserved code: the timer simply holds
          next_count = count;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `GBT_CNT_MIN;
      dir <= gbt_pkg::gbt_dir_up;
    end else begin
      count <= next_count;
      dir <= next_dir;
    end
  end

  assign ctl.count = count;
  assign ctl.dir_down = (dir == gbt_pkg::gbt_dir_down);

  // ========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_hold;
    !ctl.run && !ext_rst |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Counter moved while stopped");

  property p_inc_step;
    ctl.run && ctl.tick && !ext_rst && (mode == gbt_pkg::gbt_mode_inc) &&
    !hit |=> count == $past(count) + `GBT_CNT_STEP;
  endproperty
  a_inc_step: assert property (p_inc_step)
    else $error("Increment mode did not step by one");

  property p_match_clear;
    ctl.run && ctl.tick && !ext_rst && (mode == gbt_pkg::gbt_mode_inc) &&
    hit |=> count == `GBT_CNT_MIN;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("Match did not reset counter");

  property p_top_turn;
    ctl.run && ctl.tick && !ext_rst && (mode == gbt_pkg::gbt_mode_updn) &&
    !ctl.dir_down && (count == `GBT_CNT_MAX)
    |=> ctl.dir_down && (count == `GBT_CNT_MAX - `GBT_CNT_STEP);
  endproperty
  a_top_turn: assert property (p_top_turn)
    else $error("No reversal at top");

  property p_match_turn;
    ctl.run && ctl.tick && !ext_rst && (mode == gbt_pkg::gbt_mode_updn) &&
    !ctl.dir_down && turn |=> ctl.dir_down && (count == $past(ctl.cmp));
  endproperty
  a_match_turn: assert property (p_match_turn)
    else $error("No reversal two counts after match");

  property p_bottom_turn;
    ctl.run && ctl.tick && !ext_rst && (mode == gbt_pkg::gbt_mode_updn) &&
    ctl.dir_down && (count == `GBT_CNT_MIN)
    |=> !ctl.dir_down && (count == `GBT_CNT_STEP);
  endproperty
  a_bottom_turn: assert property (p_bottom_turn)
    else $error("No reversal at bottom");

  property p_ext_rst;
    ext_rst |=> (count == `GBT_CNT_MIN) && !ctl.dir_down;
  endproperty
  a_ext_rst: assert property (p_ext_rst)
    else $error("Pin reset not applied");

  property p_free_run;
    (ctl.rsrc == `GBT_RSRC_NONE) |-> !ext_rst;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("Reset applied with no source");

  property p_rsvd_hold;
    (mode == gbt_pkg::gbt_mode_rsvd) && !ext_rst |=> $stable(count);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold)
    else $error("Reserved mode moved counter");
endmodule : gbt_core
`default_nettype wire

//--- bench/gbt_sw_model.sv
// AXI4-Lite master standing in for software at the timer registers
`timescale 1ns/1ps
`default_nettype none
`include "gbt_regs.svh"
module gbt_sw_model (
  // Clock
  input wire logic aclk,
  // Write side
  output logic [`GBT_ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [`GBT_DATA_W-1:0] wdata,
  output logic [`GBT_STRB_W-1:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read side
  output logic [`GBT_ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [`GBT_DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
    rready = 1'h0;
  end

  // ==========================================================================
  // Write: handshakes judged mid-cycle, so the edge that follows is the one
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha;
    logic hw;
    logic hb;
    hb = 1'h0;
    if (a == `GBT_OFS_CTRL1 && d[6:5] == 2'h3) d[6:5] = 2'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask : wr

  // ==========================================================================
  // Read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha;
    logic hr;
    hr = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask : rd
endmodule : gbt_sw_model
`default_nettype wire

//--- bench/group_base_timer_updown_tb_top.sv
// Self-checking testbench of the group base timer
`timescale 1ns/1ps
`default_nettype none
`include "gbt_regs.svh"
module group_base_timer_updown_tb_top;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } gbt_row_t;
  logic aclk, aresetn, pin0_n, pin1_n, ph_a, ph_b;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_v, c;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] mx;
  logic sd, su;
  int err_total = 0, checked = 0, cycles = 0;
  gbt_row_t rows [6] = '{
    '{`GBT_OFS_CTRL1, 32'h0000_ff9b, 32'h0000_009b, 2'h0},
    '{`GBT_OFS_CMP0, 32'h1234_5678, 32'h0000_5678, 2'h0},
    '{`GBT_OFS_DIV, 32'h0000_abcd, 32'h0000_abcd, 2'h0},
    '{`GBT_OFS_COUNT, 32'h0000_1111, 32'h0000_0000, 2'h0},
    '{8'h14, 32'h0000_ffff, 32'h0000_0000, 2'h2},
    '{`GBT_OFS_START, 32'h0000_0003, 32'h0000_0003, 2'h0}};
  // Reset source, pin zero, pin one, counter expected held at zero
  logic [5:0] prow [5] = '{6'h0b, 6'h0c, 6'h15, 6'h12, 6'h00};

  gbt_top u_gbt_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin_zero_n(pin0_n), .ext_irq_pin_one_n(pin1_n),
    .phase_a(ph_a), .phase_b(ph_b));
  gbt_sw_model u_gbt_sw_model (.aclk, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_gbt_sw_model.wr(a, d, rs);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_gbt_sw_model.rd(a, rd_v, rs);
  endtask : rd
  // Pulse is long enough to clear the pin filter on both levels
  task automatic pulse();
    ph_a <= 1'h1;
    repeat (8) @(posedge aclk);
    ph_a <= 1'h0;
    repeat (8) @(posedge aclk);
  endtask : pulse
  task automatic clear_count();
    pin0_n <= 1'h0;
    repeat (10) @(posedge aclk);
    pin0_n <= 1'h1;
  endtask : clear_count
  task report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Clock, reset and timeout
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  // The up/down wrap test alone needs some 66000 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    aresetn = 1'h0;
    pin0_n = 1'h1;
    pin1_n = 1'h1;
    ph_a = 1'h0;
    ph_b = 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(rd_v, 32'h0000_0000);
      wr(rows[i].a, rows[i].d);
      chk(32'(rs), 32'(rows[i].r));
      rd(rows[i].a);
      chk(rd_v, rows[i].e);
      chk(32'(rs), 32'(rows[i].r));
    end
    // Start by either bit, hold while stopped
    wr(`GBT_OFS_CTRL1, 32'h0000_0000);
    wr(`GBT_OFS_DIV, 32'h0000_0000);
    wr(`GBT_OFS_START, 32'h0000_0000);
    rd(`GBT_OFS_COUNT);
    c = rd_v;
    wr(`GBT_OFS_START, 32'h0000_0001);
    repeat (20) @(posedge aclk);
    wr(`GBT_OFS_START, 32'h0000_0000);
    rd(`GBT_OFS_COUNT);
    chk({31'h0, rd_v[15:0] > c[15:0]}, 32'h0000_0001);
    c = rd_v;
    repeat (20) @(posedge aclk);
    rd(`GBT_OFS_COUNT);
    chk(rd_v, c);
    wr(`GBT_OFS_START, 32'h0000_0002);
    repeat (20) @(posedge aclk);
    wr(`GBT_OFS_START, 32'h0000_0000);
    rd(`GBT_OFS_COUNT);
    chk({31'h0, rd_v[15:0] > c[15:0]}, 32'h0000_0001);
    // Two-phase: five up steps, two down steps
    c = rd_v;
    wr(`GBT_OFS_CTRL1, 32'h0000_0040);
    wr(`GBT_OFS_START, 32'h0000_0001);
    repeat (5) pulse();
    ph_b <= 1'h1;
    repeat (8) @(posedge aclk);
    repeat (2) pulse();
    wr(`GBT_OFS_START, 32'h0000_0000);
    rd(`GBT_OFS_COUNT);
    chk({16'h0, rd_v[15:0]}, {16'h0, c[15:0] + 16'h0003});
    // Pin reset per reset source
    wr(`GBT_OFS_START, 32'h0000_0001);
    foreach (prow[i]) begin
      wr(`GBT_OFS_CTRL1, {29'h0, prow[i][5:3]});
      pin0_n <= prow[i][2];
      pin1_n <= prow[i][1];
      repeat (10) @(posedge aclk);
      rd(`GBT_OFS_COUNT);
      chk({31'h0, rd_v[15:0] == 16'h0}, {31'h0, prow[i][0]});
      pin0_n <= 1'h1;
      pin1_n <= 1'h1;
      repeat (10) @(posedge aclk);
    end
    // Increment with match reset never passes the compare value
    wr(`GBT_OFS_CMP0, 32'h0000_0005);
    wr(`GBT_OFS_DIV, 32'h0000_0003);
    wr(`GBT_OFS_CTRL1, 32'h0000_0009);
    clear_count();
    mx = 16'h0000;
    repeat (40) begin
      rd(`GBT_OFS_COUNT);
      if (rd_v[15:0] > mx) mx = rd_v[15:0];
    end
    chk({16'h0, mx}, 32'h0000_0005);
    // Up/down with match reset against compare value 5
    wr(`GBT_OFS_CMP0, 32'h0000_0005);
    wr(`GBT_OFS_DIV, 32'h0000_003f);
    wr(`GBT_OFS_CTRL1, 32'h0000_0029);
    clear_count();
    mx = 16'h0000;
    sd = 1'h0;
    su = 1'h0;
    repeat (400) begin
      rd(`GBT_OFS_COUNT);
      if (rd_v[15:0] > mx) mx = rd_v[15:0];
      if (rd_v[16]) sd = 1'h1;
      else if (sd) su = 1'h1;
    end
    chk({16'h0, mx}, 32'h0000_0006);
    chk({31'h0, sd && su}, 32'h0000_0001);
    // Up/down without match: turns down at the top, no wrap
    wr(`GBT_OFS_CTRL1, 32'h0000_0021);
    wr(`GBT_OFS_DIV, 32'h0000_0000);
    clear_count();
    repeat (65530) @(posedge aclk);
    sd = 1'h0;
    repeat (100) begin
      if (!sd) rd(`GBT_OFS_COUNT);
      sd = rd_v[16];
    end
    chk({31'h0, sd}, 32'h0000_0001);
    chk({31'h0, rd_v[15:0] > 16'hff00}, 32'h0000_0001);
    // Reset in mid-run stops the timer and clears the counter
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`GBT_OFS_COUNT);
    chk(rd_v, 32'h0000_0000);
    rd(`GBT_OFS_START);
    chk(rd_v, 32'h0000_0000);
    repeat (10) @(posedge aclk);
    rd(`GBT_OFS_COUNT);
    chk(rd_v, 32'h0000_0000);
    report_and_stop();
  end
endmodule : group_base_timer_updown_tb_top
`default_nettype wire
